// >>> verilog/accr_consts.svh
// constants for the channel calibration and configuration register bank
`ifndef ACCR_CONSTS_SVH
`define ACCR_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ACCR_ADDR_CFG        8'h1d
`define ACCR_ADDR_OCAL_HI    8'h1e
`define ACCR_ADDR_OCAL_LO    8'h1f
`define ACCR_ADDR_GCAL_HI    8'h20
`define ACCR_ADDR_GCAL_LO    8'h21

// ----------------------------------------
// field positions
// ----------------------------------------
`define ACCR_PHASE_MSB       15
`define ACCR_PHASE_LSB       6
`define ACCR_DCOFF_BIT       2
`define ACCR_MUX_MSB         1
`define ACCR_MUX_LSB         0
`define ACCR_LOBYTE_MSB      15
`define ACCR_LOBYTE_LSB      8

// ----------------------------------------
// reset values
// ----------------------------------------
`define ACCR_RST_CFG         16'h0000
`define ACCR_RST_OCAL_HI     16'h0000
`define ACCR_RST_OCAL_LO     8'h00
`define ACCR_RST_GCAL_HI     16'h8000
`define ACCR_RST_GCAL_LO     8'h00

`endif

// >>> verilog/accr_pkg.sv
// types for the channel calibration and configuration register bank
package accr_pkg;

	// input multiplexer selection
	typedef enum logic [1:0] {
		ACCR_IN_NORMAL  = 2'h0,
		ACCR_IN_SHORTED = 2'h1,
		ACCR_IN_POS_DC  = 2'h2,
		ACCR_IN_NEG_DC  = 2'h3
	} accr_input_sel_t;

	// channel configuration word as seen by the channel logic
	typedef struct packed {
		logic [9:0]      phase_delay;
		logic            dc_filter_off;
		accr_input_sel_t input_select;
	} accr_chan_cfg_t;

	// assembled calibration words
	typedef struct packed {
		logic [23:0] offset;
		logic [23:0] gain;
	} accr_cal_t;

endpackage

// >>> verilog/accr_regs.sv
// register bank holding one channel's configuration, offset and gain words
`timescale 1ns/1ps
`default_nettype none
`include "accr_consts.svh"

module accr_regs (
	input  wire logic                 mclk,
	input  wire logic                 rst,
	input  wire logic [7:0]           addr,
	input  wire logic [15:0]          wdata,
	input  wire logic                 wr_stb,
	input  wire logic                 rd_stb,
	output logic      [15:0]          rdata,
	output logic                      rd_hit,
	output accr_pkg::accr_chan_cfg_t  chan_cfg,
	output logic      [1:0]           dc_filter_mode,
	output accr_pkg::accr_cal_t       cal
);

	// ----------------------------------------
	// storage: only writable bits exist, so reserved bits cannot hold a one
	// ----------------------------------------
	logic [9:0]  phase_delay_r;
	logic        dc_filter_off_r;
	logic [1:0]  input_select_r;
	logic [15:0] offset_high_word_r;
	logic [7:0]  offset_low_byte_r;
	logic [15:0] gain_high_word_r;
	logic [7:0]  gain_low_byte_r;
	logic [15:0] rdata_nxt;
	logic        rd_hit_nxt;
	logic        wr_cfg;
	logic        wr_ocal_hi;
	logic        wr_ocal_lo;
	logic        wr_gcal_hi;
	logic        wr_gcal_lo;

	// reset image of the configuration word; each field takes its own slice
	localparam logic [15:0] CFG_RST = `ACCR_RST_CFG;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	// ----------------------------------------
	// write decode: wr_cfg is shared by the storage and the checks, the other four feed the checks only
	// ----------------------------------------
	assign wr_cfg     = wr_stb & hit(addr, `ACCR_ADDR_CFG);
	assign wr_ocal_hi = wr_stb & hit(addr, `ACCR_ADDR_OCAL_HI);
	assign wr_ocal_lo = wr_stb & hit(addr, `ACCR_ADDR_OCAL_LO);
	assign wr_gcal_hi = wr_stb & hit(addr, `ACCR_ADDR_GCAL_HI);
	assign wr_gcal_lo = wr_stb & hit(addr, `ACCR_ADDR_GCAL_LO);

	// ----------------------------------------
	// writes
	// ----------------------------------------
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase_delay_r   <= CFG_RST[`ACCR_PHASE_MSB:`ACCR_PHASE_LSB];
			dc_filter_off_r <= CFG_RST[`ACCR_DCOFF_BIT];
			input_select_r  <= CFG_RST[`ACCR_MUX_MSB:`ACCR_MUX_LSB];
		end else if (wr_cfg) begin
			phase_delay_r   <= wdata[`ACCR_PHASE_MSB:`ACCR_PHASE_LSB];
			dc_filter_off_r <= wdata[`ACCR_DCOFF_BIT];
			input_select_r  <= wdata[`ACCR_MUX_MSB:`ACCR_MUX_LSB];
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			offset_high_word_r <= `ACCR_RST_OCAL_HI;
			offset_low_byte_r  <= `ACCR_RST_OCAL_LO;
		end else if (wr_stb) begin
			if (hit(addr, `ACCR_ADDR_OCAL_HI)) begin
				offset_high_word_r <= wdata;
			end
			if (hit(addr, `ACCR_ADDR_OCAL_LO)) begin
				offset_low_byte_r <= wdata[`ACCR_LOBYTE_MSB:`ACCR_LOBYTE_LSB];
			end
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gain_high_word_r <= `ACCR_RST_GCAL_HI;
			gain_low_byte_r  <= `ACCR_RST_GCAL_LO;
		end else if (wr_stb) begin
			if (hit(addr, `ACCR_ADDR_GCAL_HI)) begin
				gain_high_word_r <= wdata;
			end
			if (hit(addr, `ACCR_ADDR_GCAL_LO)) begin
				gain_low_byte_r <= wdata[`ACCR_LOBYTE_MSB:`ACCR_LOBYTE_LSB];
			end
		end
	end

	// ----------------------------------------
	// reads: unmapped addresses return zero
	// ----------------------------------------
	always_comb begin
		rdata_nxt  = 16'h0000;
		rd_hit_nxt = 1'h1;
		case (addr)
			`ACCR_ADDR_CFG:     rdata_nxt = {phase_delay_r, 3'h0, dc_filter_off_r, input_select_r};
			`ACCR_ADDR_OCAL_HI: rdata_nxt = offset_high_word_r;
			`ACCR_ADDR_OCAL_LO: rdata_nxt = {offset_low_byte_r, 8'h00};
			`ACCR_ADDR_GCAL_HI: rdata_nxt = gain_high_word_r;
			`ACCR_ADDR_GCAL_LO: rdata_nxt = {gain_low_byte_r, 8'h00};
			default:            rd_hit_nxt = 1'h0;
		endcase
	end

	// data stands only in the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata  <= 16'h0000;
			rd_hit <= 1'h0;
		end else begin
			rdata  <= rd_stb ? rdata_nxt : 16'h0000;
			rd_hit <= rd_stb & rd_hit_nxt;
		end
	end

	// ----------------------------------------
	// outputs to the channel logic
	// ----------------------------------------
	assign chan_cfg.phase_delay   = phase_delay_r;
	assign chan_cfg.dc_filter_off = dc_filter_off_r;
	assign chan_cfg.input_select  = accr_pkg::accr_input_sel_t'(input_select_r);
	// 0 = follow global dc filter setting, 1 = forced off for this channel
	assign dc_filter_mode         = {1'h0, dc_filter_off_r};
	assign cal.offset             = {offset_high_word_r, offset_low_byte_r};
	// unsigned: 800000h is unity, ffffffh is just below 2.0
	assign cal.gain               = {gain_high_word_r, gain_low_byte_r};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence cfg_write_s;
		wr_stb && addr == `ACCR_ADDR_CFG;
	endsequence

	sequence read_any_s;
		rd_stb;
	endsequence

	sequence reset_held_s;
		rst ##1 rst;
	endsequence

	sequence cfg_read_s;
		rd_stb && addr == `ACCR_ADDR_CFG;
	endsequence

	sequence ocal_hi_read_s;
		rd_stb && addr == `ACCR_ADDR_OCAL_HI;
	endsequence

	sequence ocal_lo_read_s;
		rd_stb && addr == `ACCR_ADDR_OCAL_LO;
	endsequence

	sequence gcal_hi_read_s;
		rd_stb && addr == `ACCR_ADDR_GCAL_HI;
	endsequence

	sequence gcal_lo_read_s;
		rd_stb && addr == `ACCR_ADDR_GCAL_LO;
	endsequence

	// a write followed at once by a read of the same register
	sequence cfg_round_trip_s;
		cfg_write_s ##1 cfg_read_s;
	endsequence

	sequence ocal_hi_round_s;
		wr_ocal_hi ##1 ocal_hi_read_s;
	endsequence

	sequence ocal_lo_round_s;
		wr_ocal_lo ##1 ocal_lo_read_s;
	endsequence

	sequence gcal_hi_round_s;
		wr_gcal_hi ##1 gcal_hi_read_s;
	endsequence

	sequence gcal_lo_round_s;
		wr_gcal_lo ##1 gcal_lo_read_s;
	endsequence

	cfg_reset_value_a: assert property (@(posedge mclk) $fell(rst) |-> chan_cfg == '0)
		else $error("config not zero after reset");
	phase_write_a: assert property (@(posedge mclk) disable iff (rst)
		cfg_write_s |=> chan_cfg.phase_delay == $past(wdata[15:6]))
		else $error("phase delay not written");
	dcoff_write_a: assert property (@(posedge mclk) disable iff (rst)
		cfg_write_s |=> dc_filter_off_r == $past(wdata[2]))
		else $error("dc filter bit not written");
	mux_write_a: assert property (@(posedge mclk) disable iff (rst)
		cfg_write_s |=> input_select_r == $past(wdata[1:0]))
		else $error("input select not written");
	offset_high_a: assert property (@(posedge mclk) disable iff (rst)
		wr_stb && addr == `ACCR_ADDR_OCAL_HI |=> cal.offset[23:8] == $past(wdata))
		else $error("offset high word not written");
	offset_low_a: assert property (@(posedge mclk) disable iff (rst)
		wr_stb && addr == `ACCR_ADDR_OCAL_LO |=> cal.offset[7:0] == $past(wdata[15:8]))
		else $error("offset low byte not written");
	gain_reset_a: assert property (@(posedge mclk) $fell(rst) |-> cal.gain == 24'h800000)
		else $error("gain reset value wrong");
	gain_low_a: assert property (@(posedge mclk) disable iff (rst)
		wr_stb && addr == `ACCR_ADDR_GCAL_LO |=> cal.gain[7:0] == $past(wdata[15:8]))
		else $error("gain low byte not written");
	reserved_zero_a: assert property (@(posedge mclk) disable iff (rst)
		read_any_s ##1 (rd_hit && ($past(addr) == `ACCR_ADDR_CFG)) |-> rdata[5:3] == 3'h0)
		else $error("reserved config bits not zero");
	low_reserved_a: assert property (@(posedge mclk) disable iff (rst)
		rd_stb && (addr == `ACCR_ADDR_OCAL_LO || addr == `ACCR_ADDR_GCAL_LO) |=> rdata[7:0] == 8'h00)
		else $error("reserved low byte not zero");

	// ----------------------------------------
	// checks: reset
	// ----------------------------------------
	held_reset_a: assert property (@(posedge mclk)
		reset_held_s |-> chan_cfg == '0 && rdata == 16'h0000 && !rd_hit &&
			cal == {`ACCR_RST_OCAL_HI, `ACCR_RST_OCAL_LO, `ACCR_RST_GCAL_HI, `ACCR_RST_GCAL_LO})
		else $error("outputs not at reset values during reset");

	ocal_reset_a: assert property (@(posedge mclk) $fell(rst) |->
		cal.offset == {`ACCR_RST_OCAL_HI, `ACCR_RST_OCAL_LO})
		else $error("offset reset value wrong");

	rdata_reset_a: assert property (@(posedge mclk) $fell(rst) |->
		rdata == 16'h0000 && !rd_hit)
		else $error("read port not idle after reset");

	// ----------------------------------------
	// checks: storage
	// ----------------------------------------
	gain_high_a: assert property (@(posedge mclk) disable iff (rst)
		wr_gcal_hi |=> cal.gain[23:8] == $past(wdata))
		else $error("gain high word not written");

	dc_mode_a: assert property (@(posedge mclk) disable iff (rst)
		cfg_write_s |=> dc_filter_mode == {1'h0, $past(wdata[2])})
		else $error("dc filter mode does not follow the written bit");

	cfg_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!wr_cfg |=> $stable(chan_cfg))
		else $error("configuration changed without its write");

	ocal_hi_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!wr_ocal_hi |=> $stable(cal.offset[23:8]))
		else $error("offset high word changed without its write");

	ocal_lo_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!wr_ocal_lo |=> $stable(cal.offset[7:0]))
		else $error("offset low byte changed without its write");

	gcal_hi_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!wr_gcal_hi |=> $stable(cal.gain[23:8]))
		else $error("gain high word changed without its write");

	gcal_lo_hold_a: assert property (@(posedge mclk) disable iff (rst)
		!wr_gcal_lo |=> $stable(cal.gain[7:0]))
		else $error("gain low byte changed without its write");

	unmapped_write_a: assert property (@(posedge mclk) disable iff (rst)
		wr_stb && (addr < `ACCR_ADDR_CFG || addr > `ACCR_ADDR_GCAL_LO) |=> $stable(chan_cfg) && $stable(cal))
		else $error("unmapped write changed a register");

	// ----------------------------------------
	// checks: read path
	// ----------------------------------------
	cfg_read_a: assert property (@(posedge mclk) disable iff (rst)
		cfg_read_s |=> rd_hit && rdata == {$past(chan_cfg.phase_delay), 3'h0,
			$past(chan_cfg.dc_filter_off), $past(chan_cfg.input_select)})
		else $error("configuration read data wrong");

	ocal_hi_read_a: assert property (@(posedge mclk) disable iff (rst)
		ocal_hi_read_s |=> rd_hit && rdata == $past(cal.offset[23:8]))
		else $error("offset high read data wrong");

	ocal_lo_read_a: assert property (@(posedge mclk) disable iff (rst)
		ocal_lo_read_s |=> rd_hit && rdata == {$past(cal.offset[7:0]), 8'h00})
		else $error("offset low read data wrong");

	gcal_hi_read_a: assert property (@(posedge mclk) disable iff (rst)
		gcal_hi_read_s |=> rd_hit && rdata == $past(cal.gain[23:8]))
		else $error("gain high read data wrong");

	gcal_lo_read_a: assert property (@(posedge mclk) disable iff (rst)
		gcal_lo_read_s |=> rd_hit && rdata == {$past(cal.gain[7:0]), 8'h00})
		else $error("gain low read data wrong");

	unmapped_read_a: assert property (@(posedge mclk) disable iff (rst)
		rd_stb && (addr < `ACCR_ADDR_CFG || addr > `ACCR_ADDR_GCAL_LO) |=> rdata == 16'h0000 && !rd_hit)
		else $error("unmapped read not zero");

	rdata_idle_a: assert property (@(posedge mclk) disable iff (rst)
		!rd_stb |=> rdata == 16'h0000 && !rd_hit)
		else $error("read data standing without a read");

	read_no_disturb_a: assert property (@(posedge mclk) disable iff (rst)
		read_any_s |=> $stable(chan_cfg) && $stable(cal))
		else $error("read changed a register");

	// ----------------------------------------
	// checks: write then read back
	// ----------------------------------------
	cfg_round_trip_a: assert property (@(posedge mclk) disable iff (rst)
		cfg_round_trip_s |=> rdata == {$past(wdata[15:6], 2), 3'h0, $past(wdata[2:0], 2)})
		else $error("configuration read back wrong");

	ocal_hi_round_a: assert property (@(posedge mclk) disable iff (rst)
		ocal_hi_round_s |=> rdata == $past(wdata, 2))
		else $error("offset high read back wrong");

	ocal_lo_round_a: assert property (@(posedge mclk) disable iff (rst)
		ocal_lo_round_s |=> rdata == {$past(wdata[15:8], 2), 8'h00})
		else $error("offset low read back wrong");

	gcal_hi_round_a: assert property (@(posedge mclk) disable iff (rst)
		gcal_hi_round_s |=> rdata == $past(wdata, 2))
		else $error("gain high read back wrong");

	gcal_lo_round_a: assert property (@(posedge mclk) disable iff (rst)
		gcal_lo_round_s |=> rdata == {$past(wdata[15:8], 2), 8'h00})
		else $error("gain low read back wrong");

endmodule

`default_nettype wire

// >>> testbench/test_adc_channel_cal_config_regs.sv
// self-checking bench for the channel configuration and calibration registers
`timescale 1ns/1ps
`default_nettype none
module test_adc_channel_cal_config_regs;
	logic                     mclk;
	logic                     rst;
	logic [7:0]               addr;
	logic [15:0]              wdata;
	logic                     wr_stb;
	logic                     rd_stb;
	logic [15:0]              rdata;
	logic                     rd_hit;
	accr_pkg::accr_chan_cfg_t chan_cfg;
	logic [1:0]               dc_filter_mode;
	accr_pkg::accr_cal_t      cal;
	logic [15:0]              regs [5];
	logic [16:0]              expq [$];
	logic [16:0]              exp_rd;
	logic                     pend;
	logic [31:0]              lfsr;
	logic [7:0]               ra;
	int                       fail_count;
	int                       checks;

	accr_regs dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
		.rdata(rdata), .rd_hit(rd_hit), .chan_cfg(chan_cfg), .dc_filter_mode(dc_filter_mode), .cal(cal));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// reserved positions never hold a written one
	function automatic logic [15:0] wmask(input int i);
		return (i == 0) ? 16'hffc7 : ((i == 2 || i == 4) ? 16'hff00 : 16'hffff);
	endfunction

	task automatic chk(input string n, input logic [47:0] e, input logic [47:0] s);
		checks++;
		if (e !== s) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		rd_stb <= 1'b0;
		if (a >= 8'h1d && a <= 8'h21)
			regs[a - 8'h1d] = d & wmask(int'(a - 8'h1d));
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd_stb <= 1'b1;
		wr_stb <= 1'b0;
		expq.push_back((a >= 8'h1d && a <= 8'h21) ? {1'b1, regs[a - 8'h1d]} : 17'h0);
	endtask

	task automatic idle();
		@(posedge mclk);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		@(negedge mclk);
	endtask

	task automatic check_outs();
		chk("chan_cfg", 48'({regs[0][15:6], regs[0][2], regs[0][1:0]}), 48'(chan_cfg));
		chk("dc_filter_mode", 48'({1'b0, regs[0][2]}), 48'(dc_filter_mode));
		chk("cal", {regs[1], regs[2][15:8], regs[3], regs[4][15:8]}, cal);
	endtask

	task automatic do_reset();
		@(posedge mclk);
		rst <= 1'b1;
		regs = '{16'h0000, 16'h0000, 16'h0000, 16'h8000, 16'h0000};
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
	endtask

	task automatic read_all();
		for (int i = 0; i < 7; i++)
			rd(8'h1d + 8'(i));
		idle();
	endtask

	task automatic final_report();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// clock, monitor, watchdog
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// read answer stands only in the cycle after the strobe
	always @(posedge mclk) begin
		if (pend) begin
			exp_rd = expq.pop_front();
			chk("read", 48'(exp_rd), 48'({rd_hit, rdata}));
		end
		pend <= rd_stb && !rst;
	end

	initial begin
		#(40 * 3000);
		fail_count++;
		final_report();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 16'h0000;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		pend = 1'b0;
		lfsr = 32'ha50e;
		fail_count = 0;
		checks = 0;
		do_reset();
		read_all();
		check_outs();
		for (int i = 0; i < 4; i++) begin
			wr(8'h1d, {10'h200, 3'b111, 1'b1, 2'(i)});
			rd(8'h1d);
			idle();
			check_outs();
			chk("input_select", 48'(i), 48'(chan_cfg.input_select));
		end
		for (int i = 0; i < 60; i++) begin
			lfsr = lfsr_next(lfsr);
			ra = 8'h1d + 8'(lfsr[7:0] % 8'd6);
			wr(ra, lfsr[31:16]);
			rd(ra);
		end
		idle();
		check_outs();
		read_all();
		do_reset();
		idle();
		check_outs();
		read_all();
		repeat (2) @(posedge mclk);
		final_report();
	end
endmodule
`default_nettype wire
